// [verilog/cc_regs.svh]
`ifndef CC_REGS_SVH
`define CC_REGS_SVH

// ----------------------------------------------------------------------
// register placement
// ----------------------------------------------------------------------
// printed location is a word index; byte address is four times it
`define CC_CTRL_IDX        16'hFFFB
`define CC_CTRL_ADDR       {14'h0000, `CC_CTRL_IDX, 2'b00}

// ----------------------------------------------------------------------
// field positions of the clock control register
// ----------------------------------------------------------------------
`define CC_BIT_MOSC_STOP   7
`define CC_BIT_FB_DIS      6
`define CC_BIT_STATUS      5
`define CC_BIT_SRC         4
`define CC_BIT_RSVD        3
`define CC_DIV_HI          2
`define CC_DIV_LO          0

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define CC_CTRL_RESET      8'h04
`define CC_DIV_SLOWEST     3'h4
`define CC_DIV_FASTEST     3'h0
`define CC_RDATA_ZERO      32'h0000_0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
// old-clock instructions allowed before a switch at full main speed
`define CC_INST_AT_FX      5'h10
`define CC_INST_ONE        5'h01
// oscillator settle time, in main clock periods
`define CC_STAB_FX_PERIODS 131072
// mclk cycles per main clock period (main clock runs at mclk rate)
`define CC_MCLK_PER_FX     1

`endif

// [verilog/cc_pkg.sv]
package cc_pkg;

   // switch sequencer states
   typedef enum logic [1:0] {
      CC_ST_STAB,
      CC_ST_RUN,
      CC_ST_PEND_DIV,
      CC_ST_PEND_SUB
   } cc_state_type;

   // state of the control core
   typedef struct packed {
      cc_state_type state;
      logic         mosc_stop;
      logic         fb_dis;
      logic         src;
      logic [2:0]   div;
      logic         act_sub;
      logic [2:0]   act_div;
      logic [4:0]   inst_cnt;
      logic         tick_half;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
      logic         cpu_en;
      logic         per_en;
      logic         watch_en;
      logic         wdt_en;
      logic         osc_en;
   } cc_core_type;

   // state of the divider
   typedef struct packed {
      logic [3:0] fx_cnt;
      logic       sub_tog;
      logic       cpu_tick;
      logic       sub_cpu_tick;
   } cc_div_type;

   // state of the settle counter
   typedef struct packed {
      logic [17:0] cnt;
      logic        stable;
   } cc_stab_type;

endpackage

// [verilog/cc_clk_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface cc_clk_if;
   logic       osc_on;
   logic       stable;
   logic       fx_tick;
   logic       sub_tick;
   logic       sub_sel;
   logic [2:0] div_sel;
   logic       cpu_tick;
   logic       sub_cpu_tick;

   modport core (output osc_on, sub_tick, sub_sel, div_sel,
                 input  stable, fx_tick, cpu_tick, sub_cpu_tick);
   modport stab (input  osc_on, output stable, fx_tick);
   modport div  (input  fx_tick, sub_tick, sub_sel, div_sel,
                 output cpu_tick, sub_cpu_tick);
endinterface

`default_nettype wire

// [verilog/cc_stab.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"

module cc_stab
   import cc_pkg::*;
#(
   parameter int STAB_FX_PERIODS = `CC_STAB_FX_PERIODS
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // link to the core
   cc_clk_if.stab    cif
);

   // ----------------------------------------------------------------------
   // settle counter
   // ----------------------------------------------------------------------
   localparam int    STAB_CYCLES = STAB_FX_PERIODS * `CC_MCLK_PER_FX;
   localparam [17:0] STAB_LAST   = 18'(STAB_CYCLES - 1);

   cc_stab_type s_r;
   cc_stab_type s_nxt;

   // restart the wait each time the oscillator is switched back on
   always_comb begin
      s_nxt = s_r;
      if (!cif.osc_on) begin
         s_nxt.cnt    = 18'h00000;
         s_nxt.stable = 1'b0;
      end else if (!s_r.stable) begin
         if (s_r.cnt == STAB_LAST) begin
            s_nxt.stable = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 18'h00001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // main clock ticks only exist while running and settled
   assign cif.stable  = s_r.stable;
   assign cif.fx_tick = s_r.stable & cif.osc_on;

endmodule

`default_nettype wire

// [verilog/cc_div.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"

module cc_div
   import cc_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // link to the core
   cc_clk_if.div     cif
);

   // ----------------------------------------------------------------------
   // prescaler for the cpu tick
   // ----------------------------------------------------------------------
   cc_div_type s_r;
   cc_div_type s_nxt;
   logic [3:0] mask;

   // low bits that must all be set for a tick at the chosen ratio
   always_comb begin
      mask = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (3'(i) < cif.div_sel) begin
            mask[i] = 1'b1;
         end
      end
   end

   // free running counter keeps ticks aligned, so a ratio change at a
   // tick never yields a short period
   always_comb begin
      s_nxt              = s_r;
      s_nxt.cpu_tick     = 1'b0;
      s_nxt.sub_cpu_tick = 1'b0;
      if (cif.fx_tick) begin
         s_nxt.fx_cnt = s_r.fx_cnt + 4'h1;
      end
      if (cif.sub_tick) begin
         s_nxt.sub_tog      = ~s_r.sub_tog;
         s_nxt.sub_cpu_tick = s_r.sub_tog;
      end
      if (cif.sub_sel) begin
         s_nxt.cpu_tick = cif.sub_tick & s_r.sub_tog;
      end else begin
         s_nxt.cpu_tick = cif.fx_tick & ((s_r.fx_cnt & mask) == mask);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cif.cpu_tick     = s_r.cpu_tick;
   assign cif.sub_cpu_tick = s_r.sub_cpu_tick;

endmodule

`default_nettype wire

// [verilog/cc_top.sv]
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"

module cc_top
   import cc_pkg::*;
#(
   parameter int STAB_FX_PERIODS = `CC_STAB_FX_PERIODS
) (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // cpu standby requests and sub clock tick
   input  wire logic        SUB_TICK,
   input  wire logic        STOP_REQ,
   input  wire logic        HALT_REQ,
   // clock enables out
   output logic             CPU_CLK_EN,
   output logic             PERIPH_CLK_EN,
   output logic             WATCH_CLK_EN,
   output logic             WDT_CLK_EN,
   // oscillator control and status
   output logic             MAIN_OSC_EN,
   output logic             SUB_FB_DISABLE,
   output logic             CPU_CLOCK_STATUS
);

   // ----------------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------------
   // reset image as a typed constant, so its fields can be picked out by
   // position; a sized literal from a macro cannot take a bit-select, and
   // the typed copy also fixes the width that every field is cut from
   localparam logic [7:0] CTRL_RESET = `CC_CTRL_RESET;

   // ----------------------------------------------------------------------
   // sub blocks
   // ----------------------------------------------------------------------
   // one bundle carries the oscillator and tick signals between blocks
   cc_clk_if cif ();

   // settle counter: holds off main ticks after each oscillator start
   cc_stab #(
      .STAB_FX_PERIODS (STAB_FX_PERIODS)
   ) u_stab (
      .clk   (MCLK),
      .rst_n (RST_N),
      .cif   (cif)
   );

   // prescaler: makes the cpu tick from the main or the sub tick
   cc_div u_div (
      .clk   (MCLK),
      .rst_n (RST_N),
      .cif   (cif)
   );

   // ----------------------------------------------------------------------
   // core state
   // ----------------------------------------------------------------------
   // registered state, its next value and the image loaded in reset
   cc_core_type s_r;
   cc_core_type s_nxt;
   cc_core_type s_rst;

   // decode and helper terms, all combinational
   logic        setup;
   logic        access;
   logic        hit;
   logic        tgt_mismatch;
   logic [2:0]  tgt_div;
   logic [7:0]  ctrl_rd;
   logic        osc_want;

   // reset image: control register comes up as 04H, slowest main divide,
   // cpu held in the settle state and the main oscillator still off
   always_comb begin
      s_rst           = '0;
      s_rst.state     = CC_ST_STAB;
      s_rst.mosc_stop = CTRL_RESET[`CC_BIT_MOSC_STOP];
      s_rst.fb_dis    = CTRL_RESET[`CC_BIT_FB_DIS];
      s_rst.src       = CTRL_RESET[`CC_BIT_SRC];
      s_rst.div       = CTRL_RESET[`CC_DIV_HI:`CC_DIV_LO];
      s_rst.act_sub   = 1'b0;
      s_rst.act_div   = `CC_DIV_SLOWEST;
      s_rst.osc_en    = 1'b0;
   end

   // prohibited divide codes fall back to the slowest ratio; they still
   // read back as written, so software sees what it stored
   always_comb begin
      if (s_r.div > `CC_DIV_SLOWEST) begin
         tgt_div = `CC_DIV_SLOWEST;
      end else begin
         tgt_div = s_r.div;
      end
   end

   // a pending change exists when the written setting differs from the
   // one in use; on sub the divide bits do not matter, so a divide write
   // alone while on sub starts no switch
   assign tgt_mismatch = (s_r.src != s_r.act_sub) ||
                         (!s_r.src && (tgt_div != s_r.act_div));

   // read image; status bit shows the source really in use, not the one
   // asked for, and bit 3 is forced to zero
   assign ctrl_rd = {s_r.mosc_stop, s_r.fb_dis, s_r.act_sub, s_r.src,
                     1'b0, s_r.div};

   // main oscillator: stop bit only bites once on sub; STOP only on main
   // a stop bit written while on main is only armed: it takes effect once
   // the status has really moved to sub, so the cpu never loses its clock
   // in the middle of a switch; on sub a standby stop request is ignored,
   // since the sub oscillator keeps running anyway
   assign osc_want = !(s_r.act_sub && s_r.mosc_stop) &&
                     !(!s_r.act_sub && STOP_REQ);

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   // zero wait slave: the answer is ready in the first access cycle, so a
   // transfer always takes exactly one setup and one access cycle
   assign setup  = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && s_r.pready;
   assign hit    = (PADDR == `CC_CTRL_ADDR);

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt        = s_r;
      s_nxt.pready = 1'b0;

      // answer prepared in setup so the access phase ends in one cycle;
      // an unmapped address answers with an error and reads as zero
      if (setup) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !hit;
         if (hit && !PWRITE) begin
            s_nxt.prdata = {24'h000000, ctrl_rd};
         end else begin
            s_nxt.prdata = `CC_RDATA_ZERO;
         end
      end

      // status and bit 3 are not writable; bit 3 always reads zero
      // a prohibited divide code is stored as written; only the ratio
      // actually used is clamped
      if (access && hit && PWRITE) begin
         s_nxt.mosc_stop = PWDATA[`CC_BIT_MOSC_STOP];
         s_nxt.fb_dis    = PWDATA[`CC_BIT_FB_DIS];
         s_nxt.src       = PWDATA[`CC_BIT_SRC];
         s_nxt.div       = PWDATA[`CC_DIV_HI:`CC_DIV_LO];
      end

      // switch sequencer
      case (s_r.state)
         CC_ST_STAB: begin
            // cpu held until the oscillator has settled
            // only reset and an unknown state lead here; later restarts wait in the settle counter
            if (cif.stable) begin
               s_nxt.state = CC_ST_RUN;
            end
         end
         CC_ST_RUN: begin
            // a pending change is seen one cycle after the write lands
            if (tgt_mismatch) begin
               s_nxt.tick_half = 1'b0;
               if (s_r.src && !s_r.act_sub) begin
                  s_nxt.state = CC_ST_PEND_SUB;
               end else begin
                  s_nxt.state = CC_ST_PEND_DIV;
                  // on sub a single instruction is the longest wait
                  if (s_r.act_sub) begin
                     s_nxt.inst_cnt = `CC_INST_ONE;
                  end else begin
                     s_nxt.inst_cnt = `CC_INST_AT_FX >> s_r.act_div;
                  end
               end
            end
         end
         CC_ST_PEND_DIV: begin
            // count old-clock instructions, two cpu ticks each
            // a write during the wait retargets the change; the newest
            // setting is applied when the count ends
            if (cif.cpu_tick) begin
               s_nxt.tick_half = ~s_r.tick_half;
               if (s_r.tick_half) begin
                  s_nxt.inst_cnt = s_r.inst_cnt - 5'h01;
                  if (s_r.inst_cnt == `CC_INST_ONE) begin
                     // change lands on a tick edge, no short period
                     s_nxt.act_sub = s_r.src;
                     s_nxt.act_div = tgt_div;
                     s_nxt.state   = CC_ST_RUN;
                  end
               end
            end
         end
         CC_ST_PEND_SUB: begin
            // main-to-sub takes the divide in use; software keeps the
            // divide bits unchanged in that write
            // the first sub event ends the wait, so the old clock runs at
            // most one sub period; the next sub cpu tick is then at least
            // one sub period away, so the cpu clock sees no short period
            // a sub cpu tick still in flight from the last sub tick counts
            // as well
            if (cif.sub_tick || cif.sub_cpu_tick) begin
               s_nxt.act_sub = 1'b1;
               s_nxt.state   = CC_ST_RUN;
            end else if (!s_r.src) begin
               s_nxt.state = CC_ST_RUN;
            end
         end
         default: begin
            // an unknown state restarts from the settle wait
            s_nxt.state = CC_ST_STAB;
         end
      endcase

      // oscillator enable and clock enables, all registered
      // oscillator enable, registered so the pin never glitches
      s_nxt.osc_en   = osc_want;

      // cpu tick: held in the settle wait, in halt, and in stop on main;
      // stop is not honoured on sub, since the sub oscillator cannot stop
      s_nxt.cpu_en   = cif.cpu_tick && (s_r.state != CC_ST_STAB) &&
                       !HALT_REQ && !(STOP_REQ && !s_r.act_sub);

      // peripherals run from the main tick only and stop with it; the
      // watch takes the sub tick, which keeps going in standby
      s_nxt.per_en   = cif.fx_tick;
      s_nxt.watch_en = SUB_TICK && !s_r.fb_dis;

      // the watchdog counts only while the cpu is on the main clock
      s_nxt.wdt_en   = cif.fx_tick && !s_r.act_sub;
   end

   // synchronous reset loads the reset image
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         s_r <= s_rst;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // link to sub blocks and outputs
   // ----------------------------------------------------------------------
   // a disconnected feedback resistor means no sub ticks at all
   // the divider and the sequencer both see the gated tick
   assign cif.osc_on   = s_r.osc_en;
   assign cif.sub_tick = SUB_TICK && !s_r.fb_dis;
   assign cif.sub_sel  = s_r.act_sub;
   assign cif.div_sel  = s_r.act_div;

   // bus answer
   assign PRDATA           = s_r.prdata;
   assign PREADY           = s_r.pready;
   assign PSLVERR          = s_r.pslverr;

   // clock enables: watch and cpu are one cycle pulses, cpu steady at divide 0; peripheral stays high while main ticks run, watchdog too but only on main
   assign CPU_CLK_EN       = s_r.cpu_en;
   assign PERIPH_CLK_EN    = s_r.per_en;
   assign WATCH_CLK_EN     = s_r.watch_en;
   assign WDT_CLK_EN       = s_r.wdt_en;

   // oscillator control and status levels
   assign MAIN_OSC_EN      = s_r.osc_en;
   assign SUB_FB_DISABLE   = s_r.fb_dis;
   assign CPU_CLOCK_STATUS = s_r.act_sub;

endmodule

`default_nettype wire

// [testbench/cc_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"

module cc_top_asserts #(
   parameter int STAB_FX_PERIODS = 16
) (
   // clock, reset and bus
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [31:0] PADDR,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // standby inputs
   input wire logic        SUB_TICK,
   input wire logic        STOP_REQ,
   input wire logic        HALT_REQ,
   // clock enables and status
   input wire logic        CPU_CLK_EN,
   input wire logic        PERIPH_CLK_EN,
   input wire logic        WATCH_CLK_EN,
   input wire logic        WDT_CLK_EN,
   input wire logic        MAIN_OSC_EN,
   input wire logic        SUB_FB_DISABLE,
   input wire logic        CPU_CLOCK_STATUS
);
   // ----------------------------------------
   // helper: cycles of running oscillator
   // ----------------------------------------
   logic [17:0] on_cnt_r;

   // saturates so a long run cannot wrap it
   always_ff @(posedge MCLK) begin
      if (!RST_N || !MAIN_OSC_EN)
         on_cnt_r <= '0;
      else if (on_cnt_r != '1)
         on_cnt_r <= on_cnt_r + 18'h00001;
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_main_run;
      !CPU_CLOCK_STATUS && !STOP_REQ;
   endsequence

   AST_APB_READY: assert property (s_setup |=> PREADY ##1 !PREADY)
      else $error("bus access not answered in one cycle");
   AST_APB_ERR: assert property (PREADY |-> PSLVERR == (PADDR != `CC_CTRL_ADDR))
      else $error("bus error flag wrong for address");
   AST_OSC_RESET: assert property (@(posedge MCLK) disable iff (1'b0)
      !RST_N |=> !MAIN_OSC_EN) else $error("oscillator runs in reset");
   AST_OSC_ON_MAIN: assert property (s_main_run ##1 s_main_run |=> MAIN_OSC_EN)
      else $error("oscillator stopped while on main clock");
   AST_STOP_MAIN: assert property ((!CPU_CLOCK_STATUS && STOP_REQ) [*2]
      |=> !MAIN_OSC_EN) else $error("standby stop left oscillator on");
   AST_PERIPH_STOP: assert property (!MAIN_OSC_EN [*3] |-> !PERIPH_CLK_EN)
      else $error("peripheral tick without main clock");
   AST_SETTLE: assert property (PERIPH_CLK_EN |-> on_cnt_r >= STAB_FX_PERIODS)
      else $error("peripheral tick before settle time");
   AST_WDT_SUB: assert property (CPU_CLOCK_STATUS [*2] |-> !WDT_CLK_EN)
      else $error("watchdog tick on sub clock");
   AST_WATCH_ROUTE: assert property (SUB_TICK && !SUB_FB_DISABLE ##1 !SUB_FB_DISABLE
      |-> WATCH_CLK_EN) else $error("watch tick missing");
   AST_FB_GATE: assert property (SUB_FB_DISABLE [*2] |-> !WATCH_CLK_EN)
      else $error("watch tick with feedback off");
   AST_HALT_GATE: assert property (HALT_REQ [*3] |-> !CPU_CLK_EN)
      else $error("cpu tick during halt");
endmodule

bind cc_top cc_top_asserts #(.STAB_FX_PERIODS(STAB_FX_PERIODS)) i_asserts (
   .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .SUB_TICK(SUB_TICK),
   .STOP_REQ(STOP_REQ), .HALT_REQ(HALT_REQ), .CPU_CLK_EN(CPU_CLK_EN),
   .PERIPH_CLK_EN(PERIPH_CLK_EN), .WATCH_CLK_EN(WATCH_CLK_EN),
   .WDT_CLK_EN(WDT_CLK_EN), .MAIN_OSC_EN(MAIN_OSC_EN),
   .SUB_FB_DISABLE(SUB_FB_DISABLE), .CPU_CLOCK_STATUS(CPU_CLOCK_STATUS));

`default_nettype wire

// [testbench/cc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cc_cpu_model #(
   parameter int SUB_PERIOD = 10
) (
   // clock
   input wire logic clk,
   // commands from the bench
   input wire logic stop_cmd,
   input wire logic halt_cmd,
   input wire logic on_sub,
   // towards the block
   output var logic sub_tick = 1'b0,
   output var logic stop_req = 1'b0,
   output var logic halt_req = 1'b0
);
   int cnt = 0;

   // sub oscillator free-runs, even in reset: it cannot be stopped
   always @(posedge clk) begin
      cnt <= (cnt == SUB_PERIOD - 1) ? 0 : cnt + 1;
      sub_tick <= (cnt == SUB_PERIOD - 1);
      stop_req <= stop_cmd && !on_sub;
      halt_req <= halt_cmd;
   end
endmodule

`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"

module tb;
   localparam int          STAB = 16;
   localparam int          SUBP = 10;
   localparam logic [31:0] CTRL = `CC_CTRL_ADDR;

   logic        MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, rd;
   logic        PREADY, PSLVERR, SUB_TICK, STOP_REQ, HALT_REQ, err;
   logic        CPU_CLK_EN, PERIPH_CLK_EN, WATCH_CLK_EN, WDT_CLK_EN;
   logic        MAIN_OSC_EN, SUB_FB_DISABLE, CPU_CLOCK_STATUS;
   logic        stop_cmd = 0, halt_cmd = 0;
   int          n, failures = 0, tests_run = 0;
   int          divs[6] = '{5, 0, 1, 2, 3, 4};

   always #2.5 MCLK = ~MCLK;

   cc_top #(.STAB_FX_PERIODS(STAB)) i_dut (
      .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .SUB_TICK(SUB_TICK),
      .STOP_REQ(STOP_REQ), .HALT_REQ(HALT_REQ), .CPU_CLK_EN(CPU_CLK_EN),
      .PERIPH_CLK_EN(PERIPH_CLK_EN), .WATCH_CLK_EN(WATCH_CLK_EN),
      .WDT_CLK_EN(WDT_CLK_EN), .MAIN_OSC_EN(MAIN_OSC_EN),
      .SUB_FB_DISABLE(SUB_FB_DISABLE), .CPU_CLOCK_STATUS(CPU_CLOCK_STATUS));

   cc_cpu_model #(.SUB_PERIOD(SUBP)) i_cpu (
      .clk(MCLK), .stop_cmd(stop_cmd), .halt_cmd(halt_cmd),
      .on_sub(CPU_CLOCK_STATUS), .sub_tick(SUB_TICK),
      .stop_req(STOP_REQ), .halt_req(HALT_REQ));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task finish_test;
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one bus transfer; request held until ready is sampled high at an edge
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge MCLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1;
      k = 0;
      do begin
         @(posedge MCLK);
         k++;
      end while (PREADY !== 1'b1 && k < 50);
      // a slave that never answers counts as a mismatch
      if (PREADY !== 1'b1)
         failures++;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask

   task rdchk(input logic [31:0] exp);
      apb(0, CTRL, 0);
      chk(rd, exp);
   endtask

   function logic sig(input int s);
      case (s)
         0: return CPU_CLK_EN;
         1: return PERIPH_CLK_EN;
         2: return WATCH_CLK_EN;
         3: return WDT_CLK_EN;
         4: return CPU_CLOCK_STATUS;
         default: return !CPU_CLOCK_STATUS;
      endcase
   endfunction

   // count negedges until the chosen signal is high, bounded
   task wp(input int s, input int lim);
      n = 0;
      do begin
         @(negedge MCLK);
         n++;
      end while (sig(s) !== 1'b1 && n < lim);
   endtask

   task per(input int s, input int exp);
      wp(s, 200);
      wp(s, 200);
      chk(n, exp);
   endtask

   task none(input int s, input int len);
      wp(s, len);
      chk(n == len && sig(s) !== 1'b1, 1);
   endtask

   task idle(input int c);
      repeat (c) @(negedge MCLK);
   endtask

   // ----------------------------------------
   // watchdog and main sequence
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge MCLK);
      failures++;
      finish_test;
   end

   initial begin
      repeat (5) @(posedge MCLK);
      chk(MAIN_OSC_EN, 0);
      RST_N <= 1;
      wp(1, 100);
      chk(n >= STAB && n <= STAB + 6, 1);
      rdchk(32'h04);
      per(0, 16);
      per(3, 1);
      foreach (divs[i]) begin
         apb(1, CTRL, divs[i]);
         idle(80);
         rdchk(divs[i]);
         per(0, 1 << (divs[i] > 4 ? 4 : divs[i]));
      end
      // read-only and reserved bits do not stick
      apb(1, CTRL, 32'h2C);
      rdchk(32'h04);
      apb(0, CTRL + 4, 0);
      chk({31'h0, err}, 1);
      chk(rd, 0);
      apb(1, CTRL + 4, 32'h80);
      rdchk(32'h04);
      // stop bit first, then move to sub with the divide unchanged
      apb(1, CTRL, 32'h84);
      idle(5);
      chk(MAIN_OSC_EN, 1);
      apb(1, CTRL, 32'h94);
      wp(4, 100);
      chk(CPU_CLOCK_STATUS, 1);
      chk(n <= SUBP + 3, 1);
      rdchk(32'hB4);
      idle(3);
      chk(MAIN_OSC_EN, 0);
      per(0, 2 * SUBP);
      none(3, 60);
      apb(1, CTRL, 32'h91);
      idle(50);
      per(0, 2 * SUBP);
      // restart oscillator, wait out settle, then go back to main
      apb(1, CTRL, 32'h11);
      wp(1, STAB + 20);
      chk(PERIPH_CLK_EN, 1);
      apb(1, CTRL, 32'h02);
      wp(5, 100);
      chk(CPU_CLOCK_STATUS, 0);
      per(0, 4);
      // feedback resistor off stops the watch clock
      apb(1, CTRL, 32'h42);
      none(2, 30);
      chk(SUB_FB_DISABLE, 1);
      apb(1, CTRL, 32'h02);
      per(2, SUBP);
      // standby on main clock
      stop_cmd <= 1;
      idle(4);
      chk(MAIN_OSC_EN, 0);
      none(1, 30);
      stop_cmd <= 0;
      wp(1, STAB + 20);
      chk(PERIPH_CLK_EN, 1);
      halt_cmd <= 1;
      idle(3);
      none(0, 30);
      halt_cmd <= 0;
      per(0, 4);
      finish_test;
   end
endmodule

`default_nettype wire
